// [pkg/fpmm_defines.vh]
`ifndef FPMM_DEFINES_VH
`define FPMM_DEFINES_VH

// operation codes
`define FPMM_OP_MIN 2'h0
`define FPMM_OP_MAX 2'h1
`define FPMM_OP_AMIN 2'h2
`define FPMM_OP_AMAX 2'h3

// register-format layout: 1 sign, 17 exponent, 64 significand
`define FPMM_WIDTH 82
`define FPMM_SIGN_POS 81
`define FPMM_EXP_MSB 80
`define FPMM_EXP_LSB 64
`define FPMM_SIG_MSB 63
`define FPMM_EXP_ONES 17'h1ffff
`define FPMM_RESULT_RESET 82'h0

`endif

// [core/fpmm_unit.v]
// Summary of operation
// - min returns first operand if strictly less than second, else second
// - max returns second operand if first strictly less, else first
// - operand order matters; first and second roles never swapped
// - less-than is false whenever either operand is NaN
// - magnitude variants compare with sign bits ignored, same selection otherwise
`timescale 1ns/1ps
`include "fpmm_defines.vh"

module fpmm_unit #(
    parameter W = `FPMM_WIDTH
) (
    input wire sys_clk,
    input wire rst_b,
    input wire op_valid,
    input wire [1:0] op_sel,
    input wire [W-1:0] src_a,
    input wire [W-1:0] src_b,
    output reg res_valid,
    output reg [W-1:0] res_data
);

    // field widths derived from the register format
    localparam EXP_W = `FPMM_EXP_MSB - `FPMM_EXP_LSB + 1;
    localparam SIG_W = `FPMM_SIG_MSB + 1;

    // min and amin share the select direction
    function op_is_min;
        input [1:0] sel;
        begin
            case (sel)
                `FPMM_OP_MIN: begin
                    op_is_min = 1'b1;
                end
                `FPMM_OP_AMIN: begin
                    op_is_min = 1'b1;
                end
                default: begin
                    op_is_min = 1'b0;
                end
            endcase
        end
    endfunction

    // amin and amax compare magnitudes only
    function op_is_mag;
        input [1:0] sel;
        begin
            case (sel)
                `FPMM_OP_AMIN: begin
                    op_is_mag = 1'b1;
                end
                `FPMM_OP_AMAX: begin
                    op_is_mag = 1'b1;
                end
                default: begin
                    op_is_mag = 1'b0;
                end
            endcase
        end
    endfunction

    // exponent field of a register-format value
    function [`FPMM_EXP_MSB-`FPMM_EXP_LSB:0] exp_of;
        input [W-1:0] v;
        begin
            exp_of = v[`FPMM_EXP_MSB:`FPMM_EXP_LSB];
        end
    endfunction

    // significand field, explicit integer bit included
    function [`FPMM_SIG_MSB:0] sig_of;
        input [W-1:0] v;
        begin
            sig_of = v[`FPMM_SIG_MSB:0];
        end
    endfunction

    // nan: exponent all ones and fraction below the integer bit non-zero
    function is_nan;
        input [W-1:0] v;
        reg exp_ones;
        reg frac_nz;
        begin
            exp_ones = (exp_of(v) == `FPMM_EXP_ONES);
            frac_nz = (v[`FPMM_SIG_MSB-1:0] != 63'h0);
            is_nan = exp_ones & frac_nz;
        end
    endfunction

    // zero of either sign: every bit below the sign clear
    function is_zero;
        input [W-1:0] v;
        begin
            is_zero = (v[W-2:0] == {(W-1){1'b0}});
        end
    endfunction

    // operation decode
    wire min_mode;
    wire mag_mode;

    // operand fields
    wire sign_a;
    wire sign_b;
    wire [EXP_W-1:0] exp_a;
    wire [EXP_W-1:0] exp_b;
    wire [SIG_W-1:0] sig_a;
    wire [SIG_W-1:0] sig_b;

    // operand classes
    wire nan_a;
    wire nan_b;
    wire zero_a;
    wire zero_b;
    wire unordered;
    wire both_zero;

    // magnitude ordering, exponent first then significand
    wire exp_lt;
    wire exp_gt;
    wire exp_eq;
    wire sig_lt;
    wire sig_gt;
    wire mag_lt;
    wire mag_gt;

    // sign handling for the signed variants
    wire eff_sign_a;
    wire eff_sign_b;
    wire signs_differ;

    // selection
    reg a_lt_b;
    reg take_a;
    wire [W-1:0] pick_nxt;

    // decode the operation once per request
    assign min_mode = op_is_min(op_sel);
    assign mag_mode = op_is_mag(op_sel);

    // split both operands into fields; a stays first, b stays second
    assign sign_a = src_a[`FPMM_SIGN_POS];
    assign sign_b = src_b[`FPMM_SIGN_POS];
    assign exp_a = exp_of(src_a);
    assign exp_b = exp_of(src_b);
    assign sig_a = sig_of(src_a);
    assign sig_b = sig_of(src_b);

    // classify; any nan makes the pair unordered
    assign nan_a = is_nan(src_a);
    assign nan_b = is_nan(src_b);
    assign zero_a = is_zero(src_a);
    assign zero_b = is_zero(src_b);
    assign unordered = nan_a | nan_b;
    assign both_zero = zero_a & zero_b;

    // compare exponents, then significands when exponents tie
    assign exp_lt = (exp_a < exp_b);
    assign exp_gt = (exp_a > exp_b);
    assign exp_eq = (exp_a == exp_b);
    assign sig_lt = (sig_a < sig_b);
    assign sig_gt = (sig_a > sig_b);
    assign mag_lt = exp_lt | (exp_eq & sig_lt);
    assign mag_gt = exp_gt | (exp_eq & sig_gt);

    // magnitude ops see both signs as positive
    assign eff_sign_a = sign_a & ~mag_mode;
    assign eff_sign_b = sign_b & ~mag_mode;
    assign signs_differ = eff_sign_a ^ eff_sign_b;

    // ordered strict less-than of a against b
    always @* begin
        a_lt_b = 1'b0;
        if (unordered) begin
            a_lt_b = 1'b0;
        end else if (both_zero) begin
            a_lt_b = 1'b0; // plus and minus zero compare equal
        end else if (signs_differ) begin
            a_lt_b = eff_sign_a;
        end else if (eff_sign_a) begin
            a_lt_b = mag_gt; // both negative: larger magnitude is smaller
        end else begin
            a_lt_b = mag_lt;
        end
    end

    // min takes a on less-than, max takes a otherwise
    always @* begin
        take_a = 1'b0;
        case (min_mode)
            1'b1: begin
                take_a = a_lt_b;
            end
            default: begin
                take_a = ~a_lt_b;
            end
        endcase
    end

    // per-bit select of the untouched operand, sign included
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_pick
            assign pick_nxt[gi] = take_a ? src_a[gi] : src_b[gi];
        end
    endgenerate

    // result valid flag, one pulse per accepted request
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= op_valid;
        end
    end

    // result data, held until the next accepted request
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            res_data <= `FPMM_RESULT_RESET;
        end else if (op_valid) begin
            res_data <= pick_nxt;
        end
    end

endmodule

// [bench/fpmm_unit_checker.sv]
`timescale 1ns/1ps
module fpmm_unit_checker #(parameter W = 82) (input wire sys_clk, input wire rst_b, input wire op_valid,
    input wire [1:0] op_sel, input wire [W-1:0] src_a, input wire [W-1:0] src_b, input wire res_valid,
    input wire [W-1:0] res_data);
    // ordered finite operands and magnitude compare
    wire fin = ~&src_a[80:64] & ~&src_b[80:64];
    wire lt = src_a[80:0] < src_b[80:0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence req; op_valid; endsequence
    chk_res_pulse: assert property (req |=> res_valid) else $error("no result");
    chk_idle_quiet: assert property (!op_valid |=> !res_valid) else $error("stray result");
    chk_pick_operand: assert property (req |=> res_data == $past(src_a) || res_data == $past(src_b))
        else $error("not an operand");
    chk_min_first: assert property ((req and (op_sel == 2'h0 && fin && !src_a[81] && !src_b[81]))
        |=> res_data == $past(lt ? src_a : src_b)) else $error("bad min");
    chk_max_first: assert property ((req and (op_sel == 2'h1 && fin && !src_a[81] && !src_b[81]))
        |=> res_data == $past(lt ? src_b : src_a)) else $error("bad max");
    chk_amin_pick: assert property ((req and (op_sel == 2'h2 && fin))
        |=> res_data == $past(lt ? src_a : src_b)) else $error("bad amin");
    chk_amax_pick: assert property ((req and (op_sel == 2'h3 && fin))
        |=> res_data == $past(lt ? src_b : src_a)) else $error("bad amax");
    chk_nan_second: assert property ((req and (op_sel == 2'h0 && &src_a[80:64] && |src_a[62:0]))
        |=> res_data == $past(src_b)) else $error("bad nan min");
endmodule
bind fpmm_unit fpmm_unit_checker #(.W(W)) chk (.*);

// [bench/fp_min_max_unit_tb_top.sv]
`timescale 1ns/1ps
module fp_min_max_unit_tb_top;
    reg sys_clk = 0, rst_b = 0, op_valid = 0;
    reg [1:0] op_sel = 0;
    reg [81:0] src_a = 0, src_b = 0;
    wire res_valid;
    wire [81:0] res_data;
    integer n_fail = 0, num_checks = 0;
    localparam [81:0] P1 = 82'hffff8000000000000000, P2 = 82'h100008000000000000000;
    localparam [81:0] NAN = 82'h1ffffc000000000000000, N2 = {1'b1, P2[80:0]}, N1 = {1'b1, P1[80:0]};
    localparam [81:0] PZ = 82'h0, NZ = {1'b1, 81'h0};
    fpmm_unit uut (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op_sel(op_sel), .src_a(src_a),
        .src_b(src_b), .res_valid(res_valid), .res_data(res_data));
    always #4 sys_clk = ~sys_clk;
    // one op, result checked one cycle later
    task run(input [1:0] s, input [81:0] a, input [81:0] b, input [81:0] e); begin
        op_sel <= s; src_a <= a; src_b <= b; op_valid <= 1'b1;
        @(posedge sys_clk); op_valid <= 1'b0; #1 num_checks = num_checks + 1;
        if (res_valid !== 1'b1 || res_data !== e) begin
            n_fail = n_fail + 1; $display("[ERR] %0t %h %h", $time, res_data, e);
        end
    end endtask
    task t_sign; begin run(0, P1, P2, P1); run(0, N2, P1, N2); run(0, P1, N2, N2); run(1, N2, P1, P1); end endtask
    task t_mag; begin run(2, N2, P1, P1); run(3, N2, P1, N2); run(2, P1, N1, N1); end endtask
    task t_nan; begin run(0, NAN, P1, P1); run(0, P1, NAN, NAN); run(1, NAN, P2, NAN); end endtask
    // plus and minus zero tie, so min hands back the second one
    task t_zero; begin run(0, NZ, PZ, PZ); run(0, PZ, NZ, NZ); end endtask
    // idle cycle: no result pulse, last result held
    task t_hold; begin
        @(posedge sys_clk); #1 num_checks = num_checks + 1;
        if (res_valid !== 1'b0 || res_data !== NAN) begin
            n_fail = n_fail + 1; $display("[ERR] %0t %h %h", $time, {res_valid, res_data}, {1'b0, NAN});
        end
    end endtask
    task give_verdict; begin
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    end endtask
    initial begin #5000; n_fail = n_fail + 1; give_verdict; end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1; @(posedge sys_clk);
        t_sign;
        t_mag;
        t_nan;
        t_hold;
        t_zero;
        give_verdict;
    end
endmodule
